/* hdl/slpm_consts.svh */
// constants for the strap latch and indicator pin mux
`ifndef SLPM_CONSTS_SVH
`define SLPM_CONSTS_SVH

`define SLPM_ADDR_W          12
`define SLPM_OFF_WAKE_CTRL   12'h000
`define SLPM_OFF_SPEC_MODES  12'h004
`define SLPM_OFF_STRAP_STAT  12'h008

`define SLPM_WAKE_FSEL1_LSB  0
`define SLPM_WAKE_FSEL2_LSB  2
`define SLPM_MODES_IFACE_BIT 0
`define SLPM_STAT_IFACE_BIT  0
`define SLPM_STAT_REGDIS_BIT 1
`define SLPM_STAT_IRQSEL_BIT 2
`define SLPM_STAT_IND1_BIT   3
`define SLPM_STAT_IND2_BIT   4

`define SLPM_FSEL_DEFAULT    2'h0
`define SLPM_FSEL_IRQ        2'h1
`define SLPM_FSEL_WAKE       2'h2
`define SLPM_FSEL_LINK_ACT   2'h3

`define SLPM_RESP_OKAY       2'h0
`define SLPM_RESP_SLVERR     2'h2

`define SLPM_CLK_KHZ         20000
`define SLPM_BLINK_HALF_MS   50
`define SLPM_BLINK_CYCLES    (`SLPM_BLINK_HALF_MS * `SLPM_CLK_KHZ)
`define SLPM_BLINK_CNT_W     24

`endif

/* hdl/slpm_pkg.sv */
// types shared by the strap latch and indicator pin mux
`default_nettype none
package slpm_pkg;
	typedef logic [1:0] slpm_fsel_t;
	typedef enum {
		SLPM_REG_WAKE,
		SLPM_REG_MODES,
		SLPM_REG_STRAP,
		SLPM_REG_NONE
	} slpm_reg_t;
	typedef enum {
		SLPM_PH_SAMPLE,
		SLPM_PH_LOAD,
		SLPM_PH_RUN
	} slpm_phase_t;
endpackage
`default_nettype wire

/* hdl/slpm_sync2.sv */
// two-flop synchroniser for pin inputs
`default_nettype none
module slpm_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             aclk,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	// no reset: straps must be sampled while reset is held
	always_ff @(posedge aclk) begin
		meta     <= async_in;
		sync_out <= meta;
	end
endmodule
`default_nettype wire

/* hdl/slpm_strap_led_mux.sv */
// strap latch and indicator pin mux with an AXI4-Lite register slave
// Function
// RQ1: latch interface strap at reset release
// RQ2: low selects MII, high selects RMII
// RQ3: load interface mode bit on release
// RQ4: sample regulator strap once after power good
// RQ5: low regulator strap enables core regulator
// RQ6: latch irq select strap at POR and release
// RQ7: high irq select makes pin interrupt output
// RQ8: low irq select makes pin data input
// RQ9: controller routes irq when EEE and WoL
// RQ10: each indicator function from own field
// RQ11: first indicator link, blink on carrier
// RQ12: second indicator active at 100 Mbps
// RQ13: first indicator starts as link/activity
// RQ14: first polarity follows regulator strap
// RQ15: second starts as speed, may carry events
// RQ16: second active low when irq select high
// RQ17: second active high when irq select low
// RQ18: second field 11 shows link/activity
// RQ19: blink at visible clock-derived rate
// RQ20: straps sampled only during reset
`default_nettype none
`include "slpm_consts.svh"
module slpm_strap_led_mux
	import slpm_pkg::*;
#(
	parameter int BLINK_CYCLES = `SLPM_BLINK_CYCLES,
	parameter int CNT_W        = `SLPM_BLINK_CNT_W
) (
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    power_good,
	input  wire logic                    iface_select_strap,
	input  wire logic                    first_indicator_in,
	output logic                         first_indicator_out,
	output logic                         first_indicator_oe,
	input  wire logic                    second_indicator_in,
	output logic                         second_indicator_out,
	output logic                         second_indicator_oe,
	input  wire logic                    irq_pin_in,
	output logic                         interrupt_out_n,
	output logic                         irq_pin_oe,
	output logic                         tx_data_bit_four,
	output logic                         regulator_disable,
	output logic                         iface_rmii,
	input  wire logic                    link_up,
	input  wire logic                    carrier_sense,
	input  wire logic                    speed_100,
	input  wire logic                    line_isolated,
	input  wire logic                    irq_request,
	input  wire logic                    wake_event,
	input  wire logic [`SLPM_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [`SLPM_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready
);
	generate
		if (BLINK_CYCLES < 2 || BLINK_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_blink
			$error("blink count does not fit the counter");
		end
	endgenerate

	// ---------------------------------------------------------------
	// pin synchronisers
	logic [4:0]  pins_raw;
	logic [4:0]  pins_s;
	logic        pwr_s;
	logic        iface_pin_s;
	logic        ind1_pin_s;
	logic        ind2_pin_s;
	logic        irq_pin_s;

	assign pins_raw = {power_good, iface_select_strap, first_indicator_in,
		second_indicator_in, irq_pin_in};

	slpm_sync2 #(
		.WIDTH(5)
	) u_sync (
		.aclk    (aclk),
		.async_in(pins_raw),
		.sync_out(pins_s)
	);

	assign pwr_s       = pins_s[4];
	assign iface_pin_s = pins_s[3];
	assign ind1_pin_s  = pins_s[2];
	assign ind2_pin_s  = pins_s[1];
	assign irq_pin_s   = pins_s[0];

	// ---------------------------------------------------------------
	// reset sequencing
	slpm_phase_t phase;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase <= SLPM_PH_SAMPLE;
		end else begin
			case (phase)
				SLPM_PH_SAMPLE: phase <= SLPM_PH_LOAD;
				SLPM_PH_LOAD:   phase <= SLPM_PH_RUN;
				SLPM_PH_RUN:    phase <= SLPM_PH_RUN;
				default:        phase <= SLPM_PH_SAMPLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// strap latches
	logic iface_strap_q;
	logic irqsel_strap_q;
	logic reg_sampled;

	// tracking while held gives the level seen at the release edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iface_strap_q  <= iface_pin_s;  // [RQ1] [RQ20]
			irqsel_strap_q <= ind2_pin_s;   // [RQ6] [RQ20]
		end
	end

	// power-on sample survives later external resets; only a power drop re-arms it
	always_ff @(posedge aclk) begin
		if (!pwr_s) begin
			reg_sampled       <= 1'b0;
			regulator_disable <= 1'b0;
		end else if (!aresetn && !reg_sampled) begin
			reg_sampled       <= 1'b1;
			regulator_disable <= ind1_pin_s;  // [RQ4] [RQ5] [RQ20]
		end
	end

	// ---------------------------------------------------------------
	// registers
	slpm_fsel_t fsel1;
	slpm_fsel_t fsel2;
	logic       aw_full;
	logic       w_full;
	logic       next_aw_full;
	logic       next_w_full;
	logic       do_write;
	logic [`SLPM_ADDR_W-1:0] aw_addr;
	logic [7:0] w_byte0;
	logic       w_lane0;
	slpm_reg_t  wr_reg;

	function automatic slpm_reg_t reg_decode(input logic [`SLPM_ADDR_W-1:0] a);
		case (a)
			`SLPM_OFF_WAKE_CTRL:  reg_decode = SLPM_REG_WAKE;
			`SLPM_OFF_SPEC_MODES: reg_decode = SLPM_REG_MODES;
			`SLPM_OFF_STRAP_STAT: reg_decode = SLPM_REG_STRAP;
			default:              reg_decode = SLPM_REG_NONE;
		endcase
	endfunction

	assign do_write = aw_full && w_full && !s_axi_bvalid;
	assign wr_reg   = reg_decode(aw_addr);

	always_comb begin
		next_aw_full = aw_full;
		next_w_full  = w_full;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_full = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_full = 1'b1;
		end
		if (do_write) begin
			next_aw_full = 1'b0;
			next_w_full  = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_addr       <= '0;
			w_byte0       <= 8'h00;
			w_lane0       <= 1'b0;
		end else begin
			aw_full       <= next_aw_full;
			w_full        <= next_w_full;
			s_axi_awready <= !next_aw_full && !do_write &&
				!(s_axi_bvalid && !s_axi_bready);
			s_axi_wready  <= !next_w_full && !do_write &&
				!(s_axi_bvalid && !s_axi_bready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_byte0 <= s_axi_wdata[7:0];
				w_lane0 <= s_axi_wstrb[0];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `SLPM_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (wr_reg == SLPM_REG_NONE) ? `SLPM_RESP_SLVERR : `SLPM_RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// field resets to 00 so both pins come up as indicators
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fsel1 <= `SLPM_FSEL_DEFAULT;  // [RQ13]
			fsel2 <= `SLPM_FSEL_DEFAULT;  // [RQ15]
		end else if (do_write && w_lane0 && wr_reg == SLPM_REG_WAKE) begin
			fsel1 <= w_byte0[`SLPM_WAKE_FSEL1_LSB +: 2];  // [RQ10]
			fsel2 <= w_byte0[`SLPM_WAKE_FSEL2_LSB +: 2];  // [RQ10]
		end
	end

	// mode bit loads from the strap once, then software owns it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			iface_rmii <= 1'b0;
		end else if (phase == SLPM_PH_LOAD) begin
			iface_rmii <= iface_strap_q;  // [RQ2] [RQ3]
		end else if (do_write && w_lane0 && wr_reg == SLPM_REG_MODES) begin
			iface_rmii <= w_byte0[`SLPM_MODES_IFACE_BIT];
		end
	end

	// read channel
	slpm_reg_t rd_reg;
	logic [31:0] rd_word;

	assign rd_reg = reg_decode(s_axi_araddr);

	always_comb begin
		rd_word = 32'h0000_0000;
		case (rd_reg)
			SLPM_REG_WAKE: begin
				rd_word[`SLPM_WAKE_FSEL1_LSB +: 2] = fsel1;
				rd_word[`SLPM_WAKE_FSEL2_LSB +: 2] = fsel2;
			end
			SLPM_REG_MODES: rd_word[`SLPM_MODES_IFACE_BIT] = iface_rmii;  // [RQ3]
			SLPM_REG_STRAP: begin
				rd_word[`SLPM_STAT_IFACE_BIT]  = iface_strap_q;
				rd_word[`SLPM_STAT_REGDIS_BIT] = regulator_disable;
				rd_word[`SLPM_STAT_IRQSEL_BIT] = irqsel_strap_q;
				rd_word[`SLPM_STAT_IND1_BIT]   = first_indicator_out;
				rd_word[`SLPM_STAT_IND2_BIT]   = second_indicator_out;
			end
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `SLPM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= (rd_reg == SLPM_REG_NONE) ? `SLPM_RESP_SLVERR : `SLPM_RESP_OKAY;
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// activity blink
	logic [CNT_W-1:0] blink_cnt;
	logic             blink_on;

	// restarting in the lit phase means bursts shorter than BLINK_CYCLES do not flash
	always_ff @(posedge aclk) begin
		if (!aresetn || !carrier_sense) begin
			blink_cnt <= '0;
			blink_on  <= 1'b1;
		end else if (blink_cnt == CNT_W'(BLINK_CYCLES - 1)) begin
			blink_cnt <= '0;
			blink_on  <= !blink_on;  // [RQ19]
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	logic link_act;
	logic speed_act;

	assign link_act  = link_up && blink_on;  // [RQ11]
	assign speed_act = speed_100 && !line_isolated;  // [RQ12]

	// event functions drive the pin low-true regardless of strap polarity
	function automatic logic pin_level(
		input slpm_fsel_t fsel,
		input logic       ind_act,
		input logic       act_low
	);
		case (fsel)
			`SLPM_FSEL_IRQ:  pin_level = !irq_request;
			`SLPM_FSEL_WAKE: pin_level = !wake_event;
			default:         pin_level = ind_act ^ act_low;
		endcase
	endfunction

	// ---------------------------------------------------------------
	// pin drivers; strap pins stay released during reset so they can be sensed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_indicator_oe  <= 1'b0;  // [RQ20]
			first_indicator_out <= 1'b0;
		end else begin
			first_indicator_oe  <= 1'b1;
			first_indicator_out <= pin_level(fsel1, link_act, regulator_disable);  // [RQ13] [RQ14]
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			second_indicator_oe  <= 1'b0;  // [RQ20]
			second_indicator_out <= 1'b0;
		end else begin
			second_indicator_oe <= 1'b1;
			if (fsel2 == `SLPM_FSEL_LINK_ACT) begin
				second_indicator_out <= link_act ^ irqsel_strap_q;  // [RQ18] [RQ16] [RQ17]
			end else begin
				second_indicator_out <= pin_level(fsel2, speed_act, irqsel_strap_q);  // [RQ15]
			end
		end
	end

	// shared interrupt / transmit data pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pin_oe       <= 1'b0;
			interrupt_out_n  <= 1'b1;
			tx_data_bit_four <= 1'b0;
		end else if (irqsel_strap_q) begin
			irq_pin_oe       <= 1'b1;  // [RQ7]
			interrupt_out_n  <= !irq_request;
			tx_data_bit_four <= 1'b0;
		end else begin
			irq_pin_oe       <= 1'b0;  // [RQ8]
			interrupt_out_n  <= 1'b1;
			tx_data_bit_four <= irq_pin_s;
		end
	end
endmodule
`default_nettype wire

/* verif/slpm_assertions.sv */
// port assertions for the strap latch and indicator pin mux
`default_nettype none
module slpm_assertions (
	input wire logic		aclk,
	input wire logic		aresetn,
	input wire logic		first_indicator_out,
	input wire logic		first_indicator_oe,
	input wire logic		second_indicator_out,
	input wire logic		second_indicator_oe,
	input wire logic		irq_pin_oe,
	input wire logic		interrupt_out_n,
	input wire logic		tx_data_bit_four,
	input wire logic		regulator_disable,
	input wire logic		iface_rmii,
	input wire logic		iface_select_strap,
	input wire logic		link_up,
	input wire logic		carrier_sense,
	input wire logic		speed_100,
	input wire logic		line_isolated,
	input wire logic		irq_request,
	input wire logic		wake_event,
	input wire logic [11:0]	s_axi_awaddr,
	input wire logic		s_axi_awvalid,
	input wire logic		s_axi_awready,
	input wire logic [31:0]	s_axi_wdata,
	input wire logic [3:0]	s_axi_wstrb,
	input wire logic		s_axi_wvalid,
	input wire logic		s_axi_wready
);
	timeunit 1ns;
	timeprecision 1ns;
	logic		ifs_lat;
	logic [3:0]	fs;
	// straps are held steady by the bench across reset, so the raw pin will do
	always_ff @(posedge aclk) begin
		if (!aresetn) ifs_lat <= iface_select_strap;
	end
	// copy of the function fields, trusted only while the write path is idle
	always_ff @(posedge aclk) begin
		if (!aresetn) fs <= 4'h0;
		else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			&& s_axi_awaddr == 12'h000 && s_axi_wstrb[0]) fs <= s_axi_wdata[3:0];
	end
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_oe_release: assert property (
		$rose(aresetn) |=> first_indicator_oe && second_indicator_oe)
		else $error("indicator pins not driven after release");
	a_iface_load: assert property (
		$rose(aresetn) |-> ##2 iface_rmii == ifs_lat)
		else $error("interface mode bit not loaded from strap");
	a_regdis_hold: assert property (
		$past(aresetn) |-> $stable(regulator_disable))
		else $error("regulator strap changed in operation");
	a_irqsel_hold: assert property (
		$past(aresetn) && $past(aresetn, 2) |-> $stable(irq_pin_oe))
		else $error("shared pin mode changed in operation");
	a_irq_follow: assert property (
		irq_pin_oe && $past(irq_pin_oe) |-> interrupt_out_n == !$past(irq_request))
		else $error("interrupt output does not follow request");
	a_tx_quiet: assert property (
		irq_pin_oe |-> !tx_data_bit_four)
		else $error("data bit active in interrupt mode");
	a_speed_led: assert property (
		s_axi_awready && fs[3:2] == 2'h0 |-> second_indicator_out ==
		(($past(speed_100) && !$past(line_isolated)) ^ irq_pin_oe))
		else $error("speed indicator wrong");
	a_link_led: assert property (
		s_axi_awready && fs[1:0] == 2'h0 && !$past(carrier_sense) && !$past(carrier_sense, 2)
		|-> first_indicator_out == ($past(link_up) ^ regulator_disable))
		else $error("link indicator wrong");
	a_wake_led: assert property (
		s_axi_awready && fs[3:2] == 2'h2 |-> second_indicator_out == !$past(wake_event))
		else $error("wake output on second indicator wrong");
	c_wake_led: cover property (s_axi_awready && fs[3:2] == 2'h2);
	c_act_led: cover property (s_axi_awready && fs[3:2] == 2'h3);
	c_blink: cover property (carrier_sense && $changed(first_indicator_out));
endmodule
bind slpm_strap_led_mux slpm_assertions slpm_assertions_i (.*);
`default_nettype wire

/* verif/slpm_board.sv */
// board model: strap resistors on the shared pins and the host data line
`default_nettype none
module slpm_board (
	input wire logic	ifs_pull,
	input wire logic	reg_pull,
	input wire logic	irq_pull,
	input wire logic	mac_drive,
	input wire logic	mac_bit,
	input wire logic	ind1_out,
	input wire logic	ind1_oe,
	input wire logic	ind2_out,
	input wire logic	ind2_oe,
	input wire logic	irq_out_n,
	input wire logic	irq_oe,
	output logic		ifs_pin,
	output logic		ind1_pin,
	output logic		ind2_pin,
	output logic		irq_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	// a released pin settles to its resistor, never to its last driven level
	assign ifs_pin = ifs_pull;
	assign ind1_pin = ind1_oe ? ind1_out : reg_pull;
	assign ind2_pin = ind2_oe ? ind2_out : irq_pull;
	// the host drives the shared line only in data mode
	assign irq_pin = irq_oe ? irq_out_n : (mac_drive ? mac_bit : irq_pull);
endmodule
`default_nettype wire

/* verif/slpm_strap_led_mux_tb.sv */
// self-checking bench for the strap latch and indicator pin mux
`default_nettype none
module slpm_strap_led_mux_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BLINK = 4;
	logic	aclk, aresetn, power_good, ifs_pull, reg_pull, irq_pull, mac_drive, mac_bit;
	logic	ifs_pin, ind1_pin, ind2_pin, irq_pin, o1, e1, o2, e2, int_n, irq_oe, tx4, rdis, rmii;
	logic	link, car, spd, iso, irq, wake, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr;
	logic [11:0]	awa, ara;
	logic [31:0]	wd, rdat, rd;
	logic [1:0]		bresp, rresp;
	logic [3:0]		wst;
	int				n_mismatch = 0;
	int				samples_checked = 0;
	slpm_strap_led_mux #(.BLINK_CYCLES(BLINK)) slpm_strap_led_mux_i (
		.aclk(aclk), .aresetn(aresetn), .power_good(power_good), .iface_select_strap(ifs_pin),
		.first_indicator_in(ind1_pin), .first_indicator_out(o1), .first_indicator_oe(e1),
		.second_indicator_in(ind2_pin), .second_indicator_out(o2), .second_indicator_oe(e2),
		.irq_pin_in(irq_pin), .interrupt_out_n(int_n), .irq_pin_oe(irq_oe),
		.tx_data_bit_four(tx4), .regulator_disable(rdis), .iface_rmii(rmii), .link_up(link),
		.carrier_sense(car), .speed_100(spd), .line_isolated(iso), .irq_request(irq),
		.wake_event(wake), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(wst), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rr));
	slpm_board slpm_board_i (.ifs_pull(ifs_pull), .reg_pull(reg_pull), .irq_pull(irq_pull),
		.mac_drive(mac_drive), .mac_bit(mac_bit), .ind1_out(o1), .ind1_oe(e1), .ind2_out(o2),
		.ind2_oe(e2), .irq_out_n(int_n), .irq_oe(irq_oe), .ifs_pin(ifs_pin),
		.ind1_pin(ind1_pin), .ind2_pin(ind2_pin), .irq_pin(irq_pin));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic close_out;
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'b0;
			if (wrdy) wv <= 1'b0;
		end while ((awv && !awr) || (wv && !wrdy));
		while (!bv) @(posedge aclk);
		br <= 1'b0;
		chk("bresp", er, bresp);
	endtask
	task automatic axr(input logic [11:0] a, input logic [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1'b1;
		rr <= 1'b1;
		do @(posedge aclk); while (!arr);
		arv <= 1'b0;
		do @(posedge aclk); while (!rv);
		rr <= 1'b0;
		rd = rdat;
		chk("rresp", er, rresp);
	endtask
	task automatic pins(input logic [5:0] v);
		@(posedge aclk);
		{link, car, spd, iso, irq, wake} <= v;
		repeat (3) @(posedge aclk);
	endtask
	task automatic boot(input logic i, r, q, por);
		@(posedge aclk);
		aresetn <= 1'b0;
		{ifs_pull, reg_pull, irq_pull} <= {i, r, q};
		if (por) power_good <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("oe1", 1'b0, e1);
		chk("oe2", 1'b0, e2);
		chk("irq_oe", 1'b0, irq_oe);
		power_good <= 1'b1;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask
	task automatic t_straps(input logic i, er, q);
		axr(12'h004, 2'h0);
		chk("mode", i, rd);
		chk("rmii", i, rmii);
		chk("regdis", er, rdis);
		chk("irq_oe", q, irq_oe);
		// board straps go opposite to the latched values and the host drives the shared line when the irq select strap is low
		{ifs_pull, reg_pull, irq_pull} <= ~{i, er, q};
		mac_drive <= !q;
		mac_bit <= 1'b1;
		irq <= 1'b1;
		repeat (4) @(posedge aclk);
		chk("tx4", !q, tx4);
		if (q) chk("int_n", 1'b0, int_n);
		axr(12'h008, 2'h0);
		chk("straps", {q, er, i}, rd[2:0]);
	endtask
	task automatic t_leds(input logic p1, p2);
		pins(6'b101000);
		chk("first_indicator", !p1, o1);
		chk("second_indicator", !p2, o2);
		pins(6'b001100);
		chk("first_indicator", p1, o1);
		chk("second_indicator", p2, o2);
		pins(6'b100000);
		chk("second_indicator", p2, o2);
	endtask
	task automatic t_fsel(input logic p1, p2);
		logic [1:0] c;
		for (int k = 1; k < 4; k++) begin
			c = k[1:0];
			axw(12'h000, {28'h0, c, c}, 2'h0);
			pins(6'b101010);
			axr(12'h000, 2'h0);
			chk("fsel", {28'h0, c, c}, rd);
			chk("first_indicator", (c == 2'h3) ? !p1 : c[1], o1);
			chk("second_indicator", (c == 2'h3) ? !p2 : c[1], o2);
		end
		axw(12'h000, 32'h0, 2'h0);
	endtask
	task automatic t_blink;
		logic v;
		int n;
		pins(6'b110000);
		for (int j = 0; j < 2; j++) begin
			v = o1;
			n = 0;
			while (o1 === v && n < 40) begin
				@(posedge aclk);
				n++;
			end
		end
		chk("blink", BLINK, n);
		pins(6'b000000);
	endtask
	task automatic t_bus;
		axw(12'h00c, 32'h1, 2'h2);
		axr(12'h00c, 2'h2);
		chk("rdata", 32'h0, rd);
		// lane 0 off: the function fields must not move
		wst <= 4'h0;
		axw(12'h000, 32'hf, 2'h0);
		wst <= 4'hf;
		axr(12'h000, 2'h0);
		chk("fsel", 32'h0, rd);
		// software overrides the strapped mode
		axw(12'h004, 32'h0, 2'h0);
		chk("rmii", 1'b0, rmii);
		axr(12'h004, 2'h0);
		chk("mode", 32'h0, rd);
	endtask
	initial begin
		{aresetn, power_good, ifs_pull, reg_pull, irq_pull, mac_drive, mac_bit} = '0;
		{link, car, spd, iso, irq, wake, awv, wv, br, arv, rr} = '0;
		{awa, ara, wd} = '0;
		wst = 4'hf;
		boot(1'b1, 1'b1, 1'b1, 1'b1);
		t_straps(1'b1, 1'b1, 1'b1);
		t_leds(1'b1, 1'b1);
		t_fsel(1'b1, 1'b1);
		t_blink();
		t_bus();
		// regulator strap is taken at power-on only, so it survives this reset
		boot(1'b0, 1'b0, 1'b0, 1'b0);
		t_straps(1'b0, 1'b1, 1'b0);
		t_leds(1'b1, 1'b0);
		t_fsel(1'b1, 1'b0);
		boot(1'b0, 1'b0, 1'b0, 1'b1);
		t_straps(1'b0, 1'b0, 1'b0);
		t_leds(1'b0, 1'b0);
		t_blink();
		close_out();
	end
	initial begin
		repeat (4000) @(posedge aclk);
		n_mismatch++;
		close_out();
	end
endmodule
`default_nettype wire
